// File: verilog/qri_pkg.sv
// qri_pkg.sv: constants, offsets and word layouts for the charge converter register interface
`default_nettype none
package qri_pkg;
	// register offsets from the board base
	localparam logic [15:0] OFF_BUF_FIRST  = 16'h0000;
	localparam logic [15:0] OFF_BUF_LAST   = 16'h07FC;
	localparam logic [15:0] OFF_CBLT_LAST  = 16'h07FF;
	localparam logic [15:0] OFF_FW_REV     = 16'h1000;
	localparam logic [15:0] OFF_SLOT_ID    = 16'h1002;
	localparam logic [15:0] OFF_CHAIN_ADDR = 16'h1004;
	localparam logic [15:0] OFF_OPT_SET1   = 16'h1006;
	localparam logic [15:0] OFF_OPT_CLR1   = 16'h1008;
	localparam logic [15:0] OFF_IRQ_LEVEL  = 16'h100A;
	localparam logic [15:0] OFF_IRQ_VECTOR = 16'h100C;
	localparam logic [15:0] OFF_STATUS1    = 16'h100E;
	localparam logic [15:0] OFF_CONTROL1   = 16'h1010;
	localparam logic [15:0] OFF_BASE_HI    = 16'h1012;
	localparam logic [15:0] OFF_BASE_LO    = 16'h1014;
	localparam logic [15:0] OFF_ONE_SHOT   = 16'h1016;
	localparam logic [15:0] OFF_CHAIN_CTRL = 16'h101A;
	localparam logic [15:0] OFF_EVT_THRESH = 16'h1020;
	localparam logic [15:0] OFF_STATUS2    = 16'h1022;
	localparam logic [15:0] OFF_EVCNT_LO   = 16'h1024;
	localparam logic [15:0] OFF_EVCNT_HI   = 16'h1026;
	localparam logic [15:0] OFF_EVCNT_BUMP = 16'h1028;
	localparam logic [15:0] OFF_RDOFF_BUMP = 16'h102A;
	localparam logic [15:0] OFF_TEST_LOAD  = 16'h102C;
	localparam logic [15:0] OFF_QCLR_WIN   = 16'h102E;
	localparam logic [15:0] OFF_OPT_SET2   = 16'h1032;
	localparam logic [15:0] OFF_OPT_CLR2   = 16'h1034;
	localparam logic [15:0] OFF_MT_WADDR   = 16'h1036;
	localparam logic [15:0] OFF_MT_WORD_HI = 16'h1038;
	localparam logic [15:0] OFF_MT_WORD_LO = 16'h103A;
	localparam logic [15:0] OFF_CRATE      = 16'h103C;
	localparam logic [15:0] OFF_TEST_EVENT = 16'h103E;
	localparam logic [15:0] OFF_EVCNT_CLR  = 16'h1040;
	localparam logic [15:0] OFF_PEDESTAL   = 16'h1060;
	localparam logic [15:0] OFF_MT_RADDR   = 16'h1064;
	localparam logic [15:0] OFF_SW_COMMAND = 16'h1068;
	localparam logic [15:0] OFF_SLIDE      = 16'h106A;
	localparam logic [15:0] OFF_CONV_A     = 16'h1070;
	localparam logic [15:0] OFF_CONV_B     = 16'h1072;
	localparam logic [15:0] OFF_THR_FIRST  = 16'h1080;
	localparam logic [15:0] OFF_THR_LAST   = 16'h10BF;
	localparam logic [15:0] OFF_ROM_FIRST  = 16'h8000;
	// access widths and access kinds
	localparam logic [1:0] WID_D16 = 2'h0;
	localparam logic [1:0] WID_D32 = 2'h1;
	localparam logic [1:0] WID_D64 = 2'h2;
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_CBLT   = 2'h1;
	localparam logic [1:0] MODE_MCST   = 2'h2;
	// output word type codes in bits 26..24
	localparam int          TYPE_LSB     = 24;
	localparam logic [2:0]  TYPE_HEADER  = 3'h2;
	localparam logic [2:0]  TYPE_DATUM   = 3'h0;
	localparam logic [2:0]  TYPE_EOB     = 3'h4;
	localparam logic [2:0]  TYPE_INVALID = 3'h6;
	localparam int          SLOT_LSB     = 27;
	localparam int          CRATE_LSB    = 16;
	localparam int          NCHAN_LSB    = 8;
	localparam int          CHAN_LSB     = 17;
	localparam int          UNDER_BIT    = 13;
	localparam int          OVER_BIT     = 12;
	localparam logic [31:0] INVALID_WORD = 32'h06000000;
	// option and status bit positions
	localparam int SOFT_RESET_BIT = 7;
	localparam int DATA_RESET_BIT = 2;
	localparam int ST1_DREADY_BIT = 0;
	localparam int ST1_IRQ_BIT    = 8;
	localparam int ST2_EMPTY_BIT  = 1;
	localparam int ST2_FULL_BIT   = 2;
	// bits a software reset may clear; the rest clear on hardware reset only
	localparam logic [15:0] OPT1_SW_MASK = 16'h0068;
	localparam logic [15:0] CTRL1_SW_MASK = 16'h00F0;
	// reset values
	localparam logic [15:0] CHAIN_ADDR_RST = 16'h00AA;
	localparam logic [15:0] ZERO16 = 16'h0000;
endpackage : qri_pkg
`default_nettype wire

// File: verilog/qri_register_interface.sv
// qri_register_interface.sv: slave register bank, event buffer and interrupter
`timescale 1ns/100ps
`default_nettype none
module qri_register_interface #(
	parameter int          DEPTH  = 512,           // event memory words
	parameter int          NTHR   = 32,            // threshold entries
	parameter logic [15:0] FW_REV = 16'h0101       // arbitrary revision code
) (
	input  wire logic              clk,            // 100 MHz clock
	input  wire logic              rst,            // hardware reset
	input  wire logic              acc_valid,      // access request pulse
	input  wire logic              acc_write,      // 1 write, 0 read
	input  wire logic [15:0]       acc_offset,     // offset from base
	input  wire logic [1:0]        acc_width,      // D16, D32 or D64
	input  wire logic [1:0]        acc_mode,       // single, chained, multicast
	input  wire logic [15:0]       acc_wdata,      // write data
	output logic                   acc_ack,        // access done
	output logic                   acc_berr,       // access refused
	output logic [63:0]            acc_rdata,      // read data
	input  wire logic              iack_valid,     // acknowledge cycle at our level
	output logic [2:0]             irq_level,      // active request level, 0 idle
	output logic [15:0]            rom_addr,       // rom offset
	input  wire logic [7:0]        rom_data,       // rom byte
	input  wire logic              conv_valid,     // converted channel offered
	output logic                   conv_ready,     // room for it
	input  wire logic              conv_end,       // closes the event
	input  wire logic [3:0]        conv_channel,   // channel number
	input  wire logic              conv_under,     // under threshold
	input  wire logic              conv_over,      // converter overflow
	input  wire logic [11:0]       conv_result,    // conversion result
	input  wire logic [15:0]       conv_a_value,   // converter a readback
	input  wire logic [15:0]       conv_b_value,   // converter b readback
	output logic [15:0]            control_out,    // control register to core
	output logic [15:0]            options_out,    // second option register
	output logic [15:0]            pedestal_out    // pedestal current setting
);
	import qri_pkg::*;

	localparam int AW = $clog2(DEPTH);
	// refuse sizes the pointer and threshold logic cannot serve
	if (DEPTH < 8 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("DEPTH must be a power of two, at least 8");
	end
	if (NTHR < 1 || NTHR > 32) begin : g_bad_nthr
		$error("NTHR must lie in 1..32");
	end

	logic [31:0] evmem [DEPTH];
	logic [15:0] thr_table [NTHR];
	logic [AW:0] rd_ptr, commit_ptr, data_cnt;
	logic [5:0]  chan_cnt;
	logic [15:0] slot_id, chain_addr, opt1, irq_lvl_reg, irq_vec, control1;
	logic [15:0] base_hi, base_lo, chain_ctrl, evt_thresh, test_pat, qclr_win;
	logic [15:0] opt2, crate, pedestal, slide, mt_waddr, mt_hi, mt_lo, mt_raddr;
	logic [23:0] event_counter;
	logic [15:0] events_stored;
	logic        irq_active;

	// address regions, relative offsets only
	wire in_buf  = acc_offset <= OFF_BUF_LAST;
	wire in_cblt = acc_offset <= OFF_CBLT_LAST;
	wire in_rom  = acc_offset >= OFF_ROM_FIRST;
	wire in_thr  = acc_offset >= OFF_THR_FIRST && acc_offset <= OFF_THR_LAST;
	wire [4:0] thr_idx = acc_offset[5:1];
	wire thr_ok = in_thr && (32'(thr_idx) < NTHR);

	// which register offsets exist for single and multicast access
	logic reg_read_ok, reg_write_ok, mcst_ok;
	always_comb begin
		reg_read_ok = 1'b0;
		reg_write_ok = 1'b0;
		mcst_ok = 1'b0;
		case (acc_offset)
			OFF_FW_REV, OFF_STATUS1, OFF_STATUS2, OFF_EVCNT_LO, OFF_EVCNT_HI,
			OFF_CONV_A, OFF_CONV_B: begin
				reg_read_ok = 1'b1;
			end
			OFF_SLOT_ID, OFF_CHAIN_ADDR, OFF_CHAIN_CTRL: begin
				reg_read_ok = 1'b1;
				reg_write_ok = 1'b1;
			end
			OFF_OPT_SET1, OFF_OPT_CLR1, OFF_IRQ_LEVEL, OFF_IRQ_VECTOR, OFF_CONTROL1,
			OFF_BASE_HI, OFF_BASE_LO, OFF_EVT_THRESH, OFF_TEST_LOAD, OFF_QCLR_WIN,
			OFF_OPT_SET2, OFF_CRATE, OFF_PEDESTAL: begin
				reg_read_ok = 1'b1;
				reg_write_ok = 1'b1;
				mcst_ok = 1'b1;
			end
			OFF_ONE_SHOT, OFF_EVCNT_BUMP, OFF_RDOFF_BUMP, OFF_OPT_CLR2, OFF_MT_WADDR,
			OFF_MT_WORD_HI, OFF_MT_WORD_LO, OFF_EVCNT_CLR, OFF_MT_RADDR,
			OFF_SW_COMMAND, OFF_SLIDE: begin
				reg_write_ok = 1'b1;
				mcst_ok = 1'b1;
			end
			OFF_TEST_EVENT: begin
				reg_write_ok = 1'b1;
			end
			default: begin
				reg_read_ok = thr_ok;
				reg_write_ok = thr_ok;
				mcst_ok = thr_ok;
			end
		endcase
	end

	// access qualification per mode
	wire is_d16  = acc_width == WID_D16;
	wire is_wide = acc_width == WID_D32 || acc_width == WID_D64;
	wire single  = acc_mode == MODE_SINGLE;
	wire buf_rd  = acc_valid && !acc_write && is_wide &&
	               ((single && in_buf) || (acc_mode == MODE_CBLT && in_cblt));
	wire buf_wr  = acc_valid && acc_write && single && in_buf;
	wire rom_rd  = acc_valid && !acc_write && single && in_rom;
	wire reg_rd  = acc_valid && !acc_write && single && is_d16 && reg_read_ok;
	wire reg_wr  = acc_valid && acc_write && is_d16 &&
	               ((single && reg_write_ok) || (acc_mode == MODE_MCST && mcst_ok));
	wire acc_good = buf_rd || buf_wr || rom_rd || reg_rd || reg_wr;
	wire wr_at_n  = reg_wr;
	function automatic logic hit(input logic [15:0] off);
		hit = wr_at_n && acc_offset == off;
	endfunction

	// reset sources: hardware, software, data
	// operands spelled out so the net follows every change of the bus
	wire soft_rst = opt1[SOFT_RESET_BIT] ||
	                (wr_at_n && (acc_offset == OFF_ONE_SHOT || acc_offset == OFF_SW_COMMAND));
	wire data_rst = soft_rst || opt2[DATA_RESET_BIT];
	assign rom_addr = acc_offset;

	// buffer pop count and read words
	wire [AW:0] avail = commit_ptr - rd_ptr;
	wire [AW-1:0] rd_a = rd_ptr[AW-1:0];
	wire [AW-1:0] rd_b = rd_a + AW'(1);
	wire [31:0] word_a = (avail != '0) ? evmem[rd_a] : INVALID_WORD;
	wire [31:0] word_b = (avail > (AW+1)'(1)) ? evmem[rd_b] : INVALID_WORD;
	wire two = acc_width == WID_D64;
	wire [1:0] pop_n = !buf_rd ? 2'd0 : (avail == '0) ? 2'd0 :
	                   (two && avail > (AW+1)'(1)) ? 2'd2 : 2'd1;
	wire eob_a = word_a[TYPE_LSB +: 3] == TYPE_EOB;
	wire eob_b = word_b[TYPE_LSB +: 3] == TYPE_EOB;
	wire [1:0] eob_pops = {1'b0, pop_n != 2'd0 && eob_a} + {1'b0, pop_n == 2'd2 && eob_b};

	// event assembly: header slot at commit_ptr, data behind it, end word last
	wire [AW:0] used = (commit_ptr + data_cnt + (AW+1)'(1)) - rd_ptr;
	assign conv_ready = !data_rst && (used + (AW+1)'(2) <= (AW+1)'(DEPTH));
	wire conv_take = conv_valid && conv_ready && !conv_end;
	wire conv_close = conv_valid && conv_ready && conv_end && data_cnt != '0;
	wire [AW-1:0] hdr_slot = commit_ptr[AW-1:0];
	wire [AW-1:0] dat_slot = hdr_slot + data_cnt[AW-1:0] + AW'(1);
	wire [23:0] next_event_counter = event_counter + 24'd1;
	wire [31:0] hdr_word = {slot_id[4:0], TYPE_HEADER, crate[7:0], 2'b00,
	                        chan_cnt, 8'h00};
	wire [31:0] dat_word = {slot_id[4:0], TYPE_DATUM, 3'b000, conv_channel, 1'b0,
	                        2'b00, conv_under, conv_over, conv_result};
	wire [31:0] eob_word = {slot_id[4:0], TYPE_EOB, next_event_counter};

	// event memory writes
	always_ff @(posedge clk) begin
		if (conv_take) evmem[dat_slot] <= dat_word;
		if (conv_close) begin
			evmem[hdr_slot] <= hdr_word;
			evmem[dat_slot] <= eob_word;
		end
	end

	// pointers and event counting
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_ptr <= '0;
			commit_ptr <= '0;
			data_cnt <= '0;
			chan_cnt <= '0;
			events_stored <= ZERO16;
		end else if (data_rst) begin
			rd_ptr <= '0;
			commit_ptr <= '0;
			data_cnt <= '0;
			chan_cnt <= '0;
			events_stored <= ZERO16;
		end else begin
			rd_ptr <= rd_ptr + (AW+1)'(pop_n);
			if (conv_take) begin
				data_cnt <= data_cnt + (AW+1)'(1);
				chan_cnt <= chan_cnt + 6'd1;
			end
			if (conv_valid && conv_ready && conv_end) begin
				data_cnt <= '0;
				chan_cnt <= '0;
			end
			if (conv_close) commit_ptr <= commit_ptr + data_cnt + (AW+1)'(2);
			events_stored <= events_stored + {15'd0, conv_close} - {14'd0, eob_pops};
		end
	end

	// event counter: any reset, counter clear, bump
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			event_counter <= 24'd0;
		end else if (data_rst || hit(OFF_EVCNT_CLR)) begin
			event_counter <= 24'd0;
		end else if (conv_close || hit(OFF_EVCNT_BUMP)) begin
			event_counter <= next_event_counter;
		end
	end

	// interrupt request: raise on equality, drop when count falls below
	wire irq_enabled = evt_thresh != ZERO16 && irq_lvl_reg[2:0] != 3'd0;
	wire [15:0] next_stored = events_stored + {15'd0, conv_close} - {14'd0, eob_pops};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_active <= 1'b0;
		end else if (!irq_enabled || data_rst) begin
			irq_active <= 1'b0;
		end else if (next_stored == evt_thresh) begin
			irq_active <= 1'b1;
		end else if (next_stored < evt_thresh) begin
			irq_active <= 1'b0;
		end
	end
	assign irq_level = irq_active ? irq_lvl_reg[2:0] : 3'd0;

	// hardware-only registers: base, chain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chain_addr <= CHAIN_ADDR_RST;
			base_hi <= ZERO16;
			base_lo <= ZERO16;
			chain_ctrl <= ZERO16;
		end else begin
			if (hit(OFF_CHAIN_ADDR)) chain_addr <= {8'h00, acc_wdata[7:0]};
			if (hit(OFF_BASE_HI)) base_hi <= {8'h00, acc_wdata[7:0]};
			if (hit(OFF_BASE_LO)) base_lo <= {8'h00, acc_wdata[7:0]};
			if (hit(OFF_CHAIN_CTRL)) chain_ctrl <= {14'd0, acc_wdata[1:0]};
		end
	end

	// per-bit reset: option and control bits clear by their own reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opt1 <= ZERO16;
			control1 <= ZERO16;
		end else begin
			if (hit(OFF_OPT_SET1)) opt1 <= opt1 | acc_wdata;
			else if (hit(OFF_OPT_CLR1)) opt1 <= opt1 & ~acc_wdata;
			else if (soft_rst) opt1 <= opt1 & ~OPT1_SW_MASK;
			if (hit(OFF_CONTROL1)) control1 <= acc_wdata;
			else if (soft_rst) control1 <= control1 & ~CTRL1_SW_MASK;
		end
	end

	// software-cleared configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_lvl_reg <= ZERO16;
			irq_vec <= ZERO16;
			evt_thresh <= ZERO16;
			qclr_win <= ZERO16;
			opt2 <= ZERO16;
			crate <= ZERO16;
			pedestal <= ZERO16;
			test_pat <= ZERO16;
			mt_waddr <= ZERO16;
			mt_hi <= ZERO16;
			mt_raddr <= ZERO16;
		end else if (soft_rst) begin
			irq_lvl_reg <= ZERO16;
			irq_vec <= ZERO16;
			evt_thresh <= ZERO16;
			qclr_win <= ZERO16;
			opt2 <= ZERO16;
			crate <= ZERO16;
			pedestal <= ZERO16;
			test_pat <= ZERO16;
			mt_waddr <= ZERO16;
			mt_hi <= ZERO16;
			mt_raddr <= ZERO16;
		end else begin
			if (hit(OFF_IRQ_LEVEL)) irq_lvl_reg <= {13'd0, acc_wdata[2:0]};
			if (hit(OFF_IRQ_VECTOR)) irq_vec <= {8'h00, acc_wdata[7:0]};
			if (hit(OFF_EVT_THRESH)) evt_thresh <= acc_wdata;
			if (hit(OFF_QCLR_WIN)) qclr_win <= acc_wdata;
			if (hit(OFF_OPT_SET2)) opt2 <= opt2 | acc_wdata;
			else if (hit(OFF_OPT_CLR2)) opt2 <= opt2 & ~acc_wdata;
			if (hit(OFF_CRATE)) crate <= {8'h00, acc_wdata[7:0]};
			if (hit(OFF_PEDESTAL)) pedestal <= acc_wdata;
			if (hit(OFF_TEST_LOAD)) test_pat <= acc_wdata;
			if (hit(OFF_MT_WADDR)) mt_waddr <= acc_wdata;
			if (hit(OFF_MT_WORD_HI)) mt_hi <= acc_wdata;
			if (hit(OFF_MT_RADDR)) mt_raddr <= acc_wdata;
		end
	end

	// registers no reset clears: slot, slide, memory test low word, thresholds
	always_ff @(posedge clk) begin
		if (hit(OFF_SLOT_ID)) slot_id <= {11'd0, acc_wdata[4:0]};
		if (hit(OFF_SLIDE)) slide <= acc_wdata;
		if (hit(OFF_MT_WORD_LO)) mt_lo <= acc_wdata;
		if (wr_at_n && thr_ok) thr_table[thr_idx] <= acc_wdata;
	end

	// register read selection
	wire [15:0] status1 = {7'd0, irq_active, 7'd0, avail != '0};
	wire [15:0] status2 = {13'd0, !conv_ready, avail == '0, 1'b0};
	logic [15:0] reg_rdata;
	always_comb begin
		case (acc_offset)
			OFF_FW_REV:     reg_rdata = FW_REV;
			OFF_SLOT_ID:    reg_rdata = slot_id;
			OFF_CHAIN_ADDR: reg_rdata = chain_addr;
			OFF_OPT_SET1:   reg_rdata = opt1;
			OFF_OPT_CLR1:   reg_rdata = opt1;
			OFF_IRQ_LEVEL:  reg_rdata = irq_lvl_reg;
			OFF_IRQ_VECTOR: reg_rdata = irq_vec;
			OFF_STATUS1:    reg_rdata = status1;
			OFF_CONTROL1:   reg_rdata = control1;
			OFF_BASE_HI:    reg_rdata = base_hi;
			OFF_BASE_LO:    reg_rdata = base_lo;
			OFF_CHAIN_CTRL: reg_rdata = chain_ctrl;
			OFF_EVT_THRESH: reg_rdata = evt_thresh;
			OFF_STATUS2:    reg_rdata = status2;
			OFF_EVCNT_LO:   reg_rdata = event_counter[15:0];
			OFF_EVCNT_HI:   reg_rdata = {8'h00, event_counter[23:16]};
			OFF_TEST_LOAD:  reg_rdata = test_pat;
			OFF_QCLR_WIN:   reg_rdata = qclr_win;
			OFF_OPT_SET2:   reg_rdata = opt2;
			OFF_CRATE:      reg_rdata = crate;
			OFF_PEDESTAL:   reg_rdata = pedestal;
			OFF_CONV_A:     reg_rdata = conv_a_value;
			OFF_CONV_B:     reg_rdata = conv_b_value;
			default:        reg_rdata = thr_ok ? thr_table[thr_idx] : ZERO16;
		endcase
	end

	// answer one cycle after the request; acknowledge cycles carry the vector
	wire [63:0] next_rdata = iack_valid ? {56'd0, irq_vec[7:0]} :
	                         buf_rd ? {(two ? word_b : 32'd0), word_a} :
	                         rom_rd ? {56'd0, rom_data} :
	                         reg_rd ? {48'd0, reg_rdata} : 64'd0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_ack <= 1'b0;
			acc_berr <= 1'b0;
			acc_rdata <= 64'd0;
		end else begin
			acc_ack <= (acc_valid && acc_good) || iack_valid;
			acc_berr <= acc_valid && !acc_good && !iack_valid;
			acc_rdata <= next_rdata;
		end
	end

	assign control_out = control1;
	assign options_out = opt2;
	assign pedestal_out = pedestal;
endmodule // qri_register_interface
`default_nettype wire

// File: tb/qri_checker.sv
// qri_checker.sv: bus answer and decode assertions
`timescale 1ns/100ps
`default_nettype none
module qri_checker (
	input wire logic        clk,        // clock
	input wire logic        rst,        // reset
	input wire logic        acc_valid,  // request
	input wire logic        acc_write,  // direction
	input wire logic [15:0] acc_offset, // offset
	input wire logic [1:0]  acc_width,  // width
	input wire logic [1:0]  acc_mode,   // mode
	input wire logic        acc_ack,    // accepted
	input wire logic        acc_berr,   // refused
	input wire logic [63:0] acc_rdata,  // read data
	input wire logic        iack_valid  // acknowledge
);
	import qri_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// request classes
	wire logic rd  = acc_valid && !acc_write;
	wire logic sgl = acc_mode == MODE_SINGLE;
	wire logic buf_hit = acc_offset <= OFF_BUF_LAST;
	a_one_answer: assert property (
		acc_valid |=> acc_ack != acc_berr) else $error("no single answer");
	a_reg_width: assert property (
		acc_valid && sgl && acc_offset[15:12] == 4'h1 && acc_width != WID_D16 |=> acc_berr)
		else $error("wide register access accepted");
	a_buf_type: assert property (
		rd && sgl && buf_hit && acc_width == WID_D32 |=> acc_ack && !acc_rdata[TYPE_LSB])
		else $error("buffer word type bad");
	a_buf_write: assert property (
		acc_valid && acc_write && sgl && buf_hit |=> acc_ack) else $error("buffer write refused");
	a_cblt_range: assert property (
		acc_valid && acc_mode == MODE_CBLT && acc_offset[15:11] != 5'h00 |=> acc_berr)
		else $error("chained access outside buffer");
	a_mcst_read: assert property (
		rd && acc_mode == MODE_MCST |=> acc_berr) else $error("multicast read accepted");
	a_rom_write: assert property (
		acc_valid && acc_write && acc_offset[15] |=> acc_berr) else $error("rom write accepted");
	a_gap_refused: assert property (
		acc_valid && acc_offset[15:11] == 5'h01 |=> acc_berr) else $error("unmapped accepted");
	a_iack_answer: assert property (
		iack_valid |=> acc_ack) else $error("acknowledge unanswered");
	c_buf_read: cover property (rd && sgl && buf_hit);
	c_mcst_write: cover property (acc_valid && acc_write && acc_mode == MODE_MCST);
	c_iack: cover property (iack_valid);
endmodule // qri_checker
`default_nettype wire

// File: tb/qri_master_model.sv
// qri_master_model.sv: register bus master issuing single, chained and multicast accesses, one at a time
`timescale 1ns/100ps
`default_nettype none
module qri_master_model (
	input  wire logic        clk,        // clock
	output logic             acc_valid,  // request pulse
	output logic             acc_write,  // direction
	output logic [15:0]      acc_offset, // offset
	output logic [1:0]       acc_width,  // width
	output logic [1:0]       acc_mode,   // mode
	output logic [15:0]      acc_wdata,  // write data
	input  wire logic        acc_ack,    // accepted
	input  wire logic        acc_berr,   // refused
	input  wire logic [63:0] acc_rdata   // read data
);
	int gap = 0; // idle cycles before each request
	// idle bus at time zero
	initial begin
		{acc_valid, acc_write, acc_offset, acc_width, acc_mode, acc_wdata} = '0;
	end
	// request for one edge, answer taken one edge after it
	task automatic xfer(input logic w, input logic [15:0] off, input logic [1:0] wid, md,
		input logic [15:0] wd, output logic [63:0] rd, output logic ak, be);
		repeat (gap + 1) @(posedge clk);
		acc_valid <= 1'b1;
		acc_write <= w;
		acc_offset <= off;
		acc_width <= wid;
		acc_mode <= md;
		acc_wdata <= wd;
		@(posedge clk);
		acc_valid <= 1'b0;
		acc_offset <= ~off;
		acc_wdata <= ~wd;
		@(posedge clk);
		rd = acc_rdata;
		ak = acc_ack;
		be = acc_berr;
	endtask
endmodule // qri_master_model
`default_nettype wire

// File: tb/tb_qri_register_interface.sv
// tb_qri_register_interface.sv: self-checking bench for the register interface
`timescale 1ns/100ps
`default_nettype none
module tb_qri_register_interface;
	import qri_pkg::*;
	localparam logic [1:0] W16 = WID_D16, W32 = WID_D32, W64 = WID_D64;
	localparam logic [1:0] SG = MODE_SINGLE, CB = MODE_CBLT, MC = MODE_MCST;
	logic        clk = 1'b0, rst = 1'b1, iack_valid = 1'b0, conv_valid = 1'b0, conv_end = 1'b0;
	logic        conv_over = 1'b0, conv_under = 1'b0, acc_valid, acc_write, acc_ack, acc_berr;
	logic        conv_ready, ak, be;
	logic [3:0]  conv_channel = 4'h0;
	logic [11:0] conv_result = 12'h000;
	logic [15:0] acc_offset, acc_wdata, rom_addr, control_out, options_out, pedestal_out;
	logic [1:0]  acc_width, acc_mode;
	logic [2:0]  irq_level;
	logic [7:0]  rom_data;
	logic [63:0] acc_rdata, rd;
	int          fail_count = 0, samples_checked = 0;
	assign rom_data = rom_addr[7:0] ^ 8'h5A;
	always #5 clk = ~clk;
	qri_register_interface #(.DEPTH(16)) u_qri_register_interface (.clk(clk), .rst(rst),
		.acc_valid(acc_valid), .acc_write(acc_write), .acc_offset(acc_offset),
		.acc_width(acc_width), .acc_mode(acc_mode), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
		.acc_berr(acc_berr), .acc_rdata(acc_rdata), .iack_valid(iack_valid),
		.irq_level(irq_level), .rom_addr(rom_addr), .rom_data(rom_data),
		.conv_valid(conv_valid), .conv_ready(conv_ready), .conv_end(conv_end),
		.conv_channel(conv_channel), .conv_under(conv_under), .conv_over(conv_over),
		.conv_result(conv_result), .conv_a_value(16'h1234), .conv_b_value(16'h4321),
		.control_out(control_out), .options_out(options_out), .pedestal_out(pedestal_out));
	qri_master_model u_qri_master_model (.clk(clk), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_offset(acc_offset), .acc_width(acc_width),
		.acc_mode(acc_mode), .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_berr(acc_berr),
		.acc_rdata(acc_rdata));
	task automatic chk(input logic [63:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one access, judged on ack versus berr
	task automatic acc(input logic w, input logic [15:0] off, input logic [1:0] wid, md,
		input logic [15:0] wd, input logic e);
		u_qri_master_model.xfer(w, off, wid, md, wd, rd, ak, be);
		chk({ak, be}, {!e, e});
	endtask
	task automatic finish_test();
		if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one data beat then the closing beat, then let the event land
	task automatic push(input logic [3:0] ch, input logic [11:0] res);
		@(posedge clk);
		{conv_valid, conv_channel, conv_under, conv_over, conv_result} <= {1'b1, ch, 2'b11, res};
		@(posedge clk);
		conv_end <= 1'b1;
		@(posedge clk);
		{conv_valid, conv_end} <= 2'b00;
		repeat (2) @(posedge clk);
	endtask
	task automatic t_reset();
		chk(irq_level, 3'h0);
		chk(conv_ready, 1'b1);
		acc(0, OFF_EVT_THRESH, W16, SG, 0, 0); chk(rd[15:0], 16'h0000);
		acc(0, OFF_CHAIN_ADDR, W16, SG, 0, 0); chk(rd[15:0], 16'h00AA);
		acc(0, OFF_CONV_A, W16, SG, 0, 0); chk(rd[15:0], 16'h1234);
	endtask
	task automatic t_refuse();
		acc(0, OFF_EVT_THRESH, W32, SG, 0, 1);
		acc(0, 16'h0900, W16, SG, 0, 1);
		acc(0, 16'h0800, W32, CB, 0, 1);
		acc(0, 16'h0000, W32, CB, 0, 0); chk(rd[31:0], INVALID_WORD);
		acc(0, OFF_EVT_THRESH, W16, MC, 0, 1);
		acc(1, OFF_SLIDE, W16, MC, 16'h0005, 0);
		acc(1, OFF_ROM_FIRST, W16, SG, 0, 1);
		acc(0, 16'h8010, W16, SG, 0, 0); chk(rd[7:0], 8'h4A);
		acc(1, 16'h0010, W32, SG, 16'h7777, 0);
		acc(0, 16'h07FC, W32, SG, 0, 0); chk(rd[31:0], INVALID_WORD);
		acc(0, 16'h0000, W16, SG, 0, 1);
	endtask
	task automatic t_event();
		acc(1, OFF_SLOT_ID, W16, SG, 16'h0005, 0);
		acc(1, OFF_CRATE, W16, SG, 16'h003C, 0);
		acc(1, OFF_IRQ_LEVEL, W16, SG, 16'h0003, 0);
		acc(1, OFF_IRQ_VECTOR, W16, SG, 16'h005A, 0);
		acc(1, OFF_EVT_THRESH, W16, SG, 16'h0001, 0);
		push(4'h3, 12'hABC);
		chk(irq_level, 3'h3);
		@(posedge clk) iack_valid <= 1'b1;
		@(posedge clk) iack_valid <= 1'b0;
		@(posedge clk) chk({acc_ack, acc_rdata[7:0], irq_level}, {1'b1, 8'h5A, 3'h3});
		acc(0, 16'h0000, W64, SG, 0, 0);
		chk(rd, {5'd5, TYPE_DATUM, 3'h0, 4'h3, 5'h03, 12'hABC,
			5'd5, TYPE_HEADER, 8'h3C, 2'h0, 6'd1, 8'h00});
		chk(irq_level, 3'h3);
		acc(0, 16'h0000, W64, SG, 0, 0); chk(rd, {INVALID_WORD, 5'd5, TYPE_EOB, 24'd1});
		chk(irq_level, 3'h0);
		acc(0, OFF_EVCNT_LO, W16, SG, 0, 0); chk(rd[15:0], 16'h0001);
		acc(1, OFF_EVCNT_BUMP, W16, SG, 16'h0000, 0);
		acc(0, OFF_EVCNT_LO, W16, SG, 0, 0); chk(rd[15:0], 16'h0002);
		acc(1, OFF_EVCNT_CLR, W16, SG, 16'h0000, 0);
		acc(0, OFF_EVCNT_LO, W16, SG, 0, 0); chk(rd[15:0], 16'h0000);
	endtask
	task automatic t_soft();
		u_qri_master_model.gap = 2;
		acc(1, OFF_CHAIN_ADDR, W16, SG, 16'h0055, 0);
		acc(1, OFF_CONTROL1, W16, SG, 16'h00FF, 0); chk(control_out, 16'h00FF);
		acc(1, OFF_OPT_SET2, W16, SG, 16'h0011, 0); chk(options_out, 16'h0011);
		acc(1, OFF_PEDESTAL, W16, SG, 16'h00C3, 0); chk(pedestal_out, 16'h00C3);
		acc(1, OFF_SW_COMMAND, W16, SG, 16'h0000, 0); chk(pedestal_out, 16'h0000);
		chk(control_out, 16'h000F);
		chk(options_out, 16'h0000);
		acc(0, OFF_EVT_THRESH, W16, SG, 0, 0); chk(rd[15:0], 16'h0000);
		acc(0, OFF_EVCNT_LO, W16, SG, 0, 0); chk(rd[15:0], 16'h0000);
		acc(0, OFF_CHAIN_ADDR, W16, SG, 0, 0); chk(rd[15:0], 16'h0055);
		acc(1, OFF_IRQ_LEVEL, W16, SG, 16'h0003, 0);
		push(4'h1, 12'h123);
		chk(irq_level, 3'h0);
		acc(1, OFF_IRQ_LEVEL, W16, SG, 16'h0000, 0);
		acc(1, OFF_EVT_THRESH, W16, SG, 16'h0001, 0); chk(irq_level, 3'h0);
		// hardware reset in mid-run: chain and control bits go back to defaults
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk(control_out, 16'h0000);
		acc(0, OFF_CHAIN_ADDR, W16, SG, 0, 0); chk(rd[15:0], 16'h00AA);
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_refuse();
		t_event();
		t_soft();
		finish_test();
	end
	// watchdog
	initial begin
		#50000;
		fail_count++;
		finish_test();
	end
endmodule // tb_qri_register_interface
bind qri_register_interface qri_checker u_qri_checker (.clk(clk), .rst(rst),
	.acc_valid(acc_valid), .acc_write(acc_write), .acc_offset(acc_offset),
	.acc_width(acc_width), .acc_mode(acc_mode), .acc_ack(acc_ack), .acc_berr(acc_berr),
	.acc_rdata(acc_rdata), .iack_valid(iack_valid));
`default_nettype wire
